// ---- hdl/sp_pkg.sv ----
// Serial port package: register map, field layout, types and states.
// Functional notes
// - Mode 0 shifts one bit every two clocks, whatever the timer or rate bit.
// - Mode 2 bit rate is clock/32, or clock/16 with rate_double_bit set.
// - Modes 1 and 3 bit rate is timer overflow rate times 2^double / 32.
// - Timer nibble 0010B gives overflow every 256 minus TH clocks.
// - Timer nibble 0001B gives overflow every 65536 minus 16-bit reload clocks.
// - Mode 0 moves data on line zero, clock on line one, LSB first.
// - Mode 0 buffer write loads marker one; sending starts one cycle later.
// - Mode 0 send drives data and clock, shifting right on each clock fall.
// - Mode 0 marker beside MSB means last shift, stop, set tx_done_flag.
// - Mode 0 receive starts on enable with rx_done_flag clear, loads 1FEH.
// - Mode 0 receive shifts left on clock fall, bit sampled at clock rise.
// - Mode 0 zero marker at top means last shift, load buffer, set flag.
// - Mode 1 frame: start zero, eight bits LSB first, stop one kept.
// - Mode 1 write loads marker; sending starts after next counter rollover.
// - Mode 1 start bit, then data one bit later, first shift a bit later.
// - Mode 1 marker beside MSB: last shift, stop, flag at tenth rollover.
// - Mode 1 falling edge at 16x rate resets counter and loads 1FFH.
// - Each bit is the majority of samples at counter states 7, 8 and 9.
// - A start bit that is not zero abandons the frame and hunts again.
// - Final shift stores frame only if flag clear and filter allows it.
// - After the final shift the receiver hunts for a falling edge again.
// - Mode 0 reception leaves rx_ninth_bit untouched.
package sp_pkg;

    localparam int AW = 8;

    localparam logic [AW-1:0] SP_OFF_CTRL  = 8'h00;
    localparam logic [AW-1:0] SP_OFF_BUF   = 8'h04;
    localparam logic [AW-1:0] SP_OFF_PWR   = 8'h08;
    localparam logic [AW-1:0] SP_OFF_TIMER_MODE_REG  = 8'h0c;
    localparam logic [AW-1:0] SP_OFF_TH    = 8'h10;
    localparam logic [AW-1:0] SP_OFF_RH    = 8'h14;
    localparam logic [AW-1:0] SP_OFF_RL    = 8'h18;
    localparam logic [AW-1:0] SP_OFF_STAT  = 8'h1c;
    localparam logic [AW-1:0] SP_OFF_TCNT  = 8'h20;

    // Control, power and timer mode register fields.
    localparam int SP_CTRL_MODE_LSB = 6;
    localparam int SP_CTRL_MPF      = 5;
    localparam int SP_CTRL_REN      = 4;
    localparam int SP_CTRL_RB8      = 2;
    localparam int SP_CTRL_TI       = 1;
    localparam int SP_CTRL_RI       = 0;
    localparam int SP_PWR_DOUBLE    = 7;
    localparam int SP_TIMER_MODE_REG_LSB      = 4;

    localparam logic [7:0] SP_RST_BYTE = 8'h00;

    localparam logic [1:0] SP_MODE0 = 2'h0;
    localparam logic [1:0] SP_MODE2 = 2'h2;

    localparam logic [3:0] SP_T1_AUTO8  = 4'h2;
    localparam logic [3:0] SP_T1_AUTO16 = 4'h1;
    localparam logic [7:0] SP_T8_TOP    = 8'hff;
    localparam logic [15:0] SP_T16_TOP  = 16'hffff;

    localparam logic [8:0] SP_RX0_INIT = 9'h1fe;
    localparam logic [8:0] SP_RX1_INIT = 9'h1ff;
    localparam logic [3:0] SP_SMP_A    = 4'h7;
    localparam logic [3:0] SP_SMP_B    = 4'h8;
    localparam logic [3:0] SP_SMP_C    = 4'h9;
    localparam logic [3:0] SP_DIV_LAST = 4'hf;

    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [31:0]   pwdata;
    } sp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sp_apb_rsp_t;

    typedef enum logic [1:0] {
        SP_TX_IDLE,
        SP_TX_WAIT,
        SP_TX_START,
        SP_TX_DATA
    } sp_tx_st_t;

    typedef enum logic [1:0] {
        SP_RX_IDLE,
        SP_RX_LOAD,
        SP_RX_SYNC,
        SP_RX_FRAME
    } sp_rx_st_t;

endpackage

// ---- hdl/sp_serial_port.sv ----
// Serial port: shift-register mode, 10-bit frames, bit-rate timer, APB regs.
//
// Added by the designer: the APB slave port and the placing of the registers.
module sp_serial_port (
    input  logic                clk,
    input  logic                srst,
    input  sp_pkg::sp_apb_req_t apb_req,
    output sp_pkg::sp_apb_rsp_t apb_rsp,
    input  logic                port_three_line_zero_in,
    output logic                port_three_line_zero_out,
    output logic                port_three_line_zero_oe,
    output logic                port_three_line_one
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [1:0]  mode_r;
    logic        mpf_r;
    logic        ren_r;
    logic        ti_r;
    logic        ri_r;
    logic        rb8_r;
    logic [7:0]  rxbuf_r;
    logic        smod_r;
    logic [7:0]  timer_mode_reg_r;
    logic [7:0]  th_r;
    logic [7:0]  rh_r;
    logic [7:0]  rl_r;
    logic [31:0] prdata_r;

    logic [15:0] t1_r;
    logic        half_r;
    logic [3:0]  div_r;

    logic        l0_s1_r;
    logic        l0_s2_r;
    logic        prev_r;
    logic        s7_r;
    logic        s8_r;
    logic        s0_r;
    logic        first_r;
    logic        sclk_r;

    logic [8:0]  tsr_r;
    logic [8:0]  rsr_r;

    logic        out0_r;
    logic        oe0_r;
    logic        out1_r;

    sp_pkg::sp_tx_st_t tx_st_r;
    sp_pkg::sp_rx_st_t rx_st_r;

    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB decode.

    logic        acc_w;
    logic        wr_w;
    logic        rd_setup_w;
    logic        sel_ctrl_w;
    logic        sel_buf_w;
    logic        sel_pwr_w;
    logic        sel_timer_mode_reg_w;
    logic        sel_th_w;
    logic        sel_rh_w;
    logic        sel_rl_w;
    logic        sel_stat_w;
    logic        sel_tcnt_w;
    logic        hit_w;
    logic [7:0]  wb_w;
    logic [7:0]  ctrl_rd_w;
    logic [7:0]  stat_rd_w;
    logic [31:0] rd_data_w;

    assign acc_w      = apb_req.psel & apb_req.penable;
    assign wr_w       = acc_w & apb_req.pwrite;
    assign rd_setup_w = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign wb_w       = apb_req.pwdata[7:0];

    assign sel_ctrl_w = apb_req.paddr == sp_pkg::SP_OFF_CTRL;
    assign sel_buf_w  = apb_req.paddr == sp_pkg::SP_OFF_BUF;
    assign sel_pwr_w  = apb_req.paddr == sp_pkg::SP_OFF_PWR;
    assign sel_timer_mode_reg_w = apb_req.paddr == sp_pkg::SP_OFF_TIMER_MODE_REG;
    assign sel_th_w   = apb_req.paddr == sp_pkg::SP_OFF_TH;
    assign sel_rh_w   = apb_req.paddr == sp_pkg::SP_OFF_RH;
    assign sel_rl_w   = apb_req.paddr == sp_pkg::SP_OFF_RL;
    assign sel_stat_w = apb_req.paddr == sp_pkg::SP_OFF_STAT;
    assign sel_tcnt_w = apb_req.paddr == sp_pkg::SP_OFF_TCNT;

    assign hit_w = sel_ctrl_w | sel_buf_w | sel_pwr_w | sel_timer_mode_reg_w
                 | sel_th_w | sel_rh_w | sel_rl_w | sel_stat_w
                 | sel_tcnt_w;

    assign ctrl_rd_w = {mode_r, mpf_r, ren_r, 1'b0, rb8_r, ti_r, ri_r};
    assign stat_rd_w = {4'h0, tx_st_r, rx_st_r};

    assign rd_data_w = sel_ctrl_w ? {24'h0, ctrl_rd_w}
                     : sel_buf_w  ? {24'h0, rxbuf_r}
                     : sel_pwr_w  ? {24'h0, smod_r, 7'h00}
                     : sel_timer_mode_reg_w ? {24'h0, timer_mode_reg_r}
                     : sel_th_w   ? {24'h0, th_r}
                     : sel_rh_w   ? {24'h0, rh_r}
                     : sel_rl_w   ? {24'h0, rl_r}
                     : sel_stat_w ? {24'h0, stat_rd_w}
                     : sel_tcnt_w ? {16'h0, t1_r}
                     : 32'h0;

    // Zero wait states; read data is captured in the setup cycle.
    assign apb_rsp.prdata  = prdata_r;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = acc_w & ~hit_w;

    logic wr_ctrl_w;
    logic wr_buf_w;

    assign wr_ctrl_w = wr_w & sel_ctrl_w;
    assign wr_buf_w  = wr_w & sel_buf_w;

    ////////////////////////////////////////////////////////////////////////
    // Bit-rate generation.

    logic       is_m0_w;
    logic       is_m2_w;
    logic       t8_w;
    logic       t16_w;
    logic       ovf_w;
    logic       src_w;
    logic       tick_w;
    logic       roll_w;

    assign is_m0_w = mode_r == sp_pkg::SP_MODE0;
    assign is_m2_w = mode_r == sp_pkg::SP_MODE2;
    assign t8_w  = timer_mode_reg_r[7:4] == sp_pkg::SP_T1_AUTO8;
    assign t16_w = timer_mode_reg_r[7:4] == sp_pkg::SP_T1_AUTO16;

    assign ovf_w = t8_w ? (t1_r[7:0] == sp_pkg::SP_T8_TOP)
                 : t16_w & (t1_r == sp_pkg::SP_T16_TOP);

    // Mode 2 counts clock cycles, modes 1 and 3 count overflows.
    assign src_w  = is_m2_w ? 1'b1 : ovf_w;
    assign tick_w = src_w & (smod_r | half_r);
    assign roll_w = tick_w & (div_r == sp_pkg::SP_DIV_LAST);

    always_ff @(posedge clk) begin
        if (srst) begin
            t1_r <= 16'h0000;
        end else if (ovf_w) begin
            t1_r <= t8_w ? {8'h00, th_r} : {rh_r, rl_r};
        end else if (t8_w | t16_w) begin
            t1_r <= t1_r + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            half_r <= 1'b0;
        end else if (src_w) begin
            half_r <= ~half_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive line synchroniser and mode 1 bit detector.

    logic rxd_w;
    logic det_w;
    logic bit_stb_w;
    logic maj_w;
    logic abort_w;
    logic final1_w;
    logic accept1_w;
    logic [8:0] shift1_w;

    assign rxd_w = l0_s2_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            l0_s1_r <= 1'b1;
            l0_s2_r <= 1'b1;
        end else begin
            l0_s1_r <= port_three_line_zero_in;
            l0_s2_r <= l0_s1_r;
        end
    end

    assign det_w = ~is_m0_w & ren_r & tick_w & prev_r & ~rxd_w
                 & (rx_st_r == sp_pkg::SP_RX_IDLE);

    assign bit_stb_w = tick_w & (rx_st_r == sp_pkg::SP_RX_FRAME)
                     & (div_r == sp_pkg::SP_SMP_C);
    assign maj_w = (s7_r & s8_r) | (s7_r & rxd_w)
                 | (s8_r & rxd_w);
    assign abort_w  = bit_stb_w & first_r & maj_w;
    assign final1_w = bit_stb_w & ~first_r & ~rsr_r[8];
    assign shift1_w = {rsr_r[7:0], maj_w};
    assign accept1_w = final1_w & ~ri_r & (~mpf_r | maj_w);

    always_ff @(posedge clk) begin
        if (srst) begin
            div_r <= 4'h0;
        end else if (det_w) begin
            div_r <= 4'h0;
        end else if (tick_w) begin
            div_r <= div_r + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prev_r <= 1'b1;
            s7_r   <= 1'b1;
            s8_r   <= 1'b1;
        end else if (tick_w) begin
            prev_r <= rxd_w;
            if (div_r == sp_pkg::SP_SMP_A) begin
                s7_r <= rxd_w;
            end
            if (div_r == sp_pkg::SP_SMP_B) begin
                s8_r <= rxd_w;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            first_r <= 1'b0;
        end else if (det_w) begin
            first_r <= 1'b1;
        end else if (bit_stb_w) begin
            first_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode 0 shift clock and receive.

    logic send0_w;
    logic recv0_w;
    logic act0_w;
    logic rise_w;
    logic fall_w;
    logic start0_w;
    logic final0_w;
    logic [8:0] shift0_w;

    assign send0_w = is_m0_w & (tx_st_r == sp_pkg::SP_TX_DATA);
    assign recv0_w = is_m0_w & (rx_st_r == sp_pkg::SP_RX_SYNC);
    assign act0_w  = send0_w | recv0_w;
    assign rise_w  = act0_w & ~sclk_r;
    assign fall_w  = act0_w & sclk_r;

    // The shared data line forbids starting a receive while sending.
    assign start0_w = is_m0_w & ren_r & ~ri_r
                    & (rx_st_r == sp_pkg::SP_RX_IDLE)
                    & (tx_st_r == sp_pkg::SP_TX_IDLE);
    assign shift0_w = {rsr_r[7:0], s0_r};
    assign final0_w = fall_w & recv0_w & ~rsr_r[7];

    // One toggle per clock gives a bit every two clocks.
    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_r <= 1'b0;
        end else if (act0_w) begin
            sclk_r <= ~sclk_r;
        end else begin
            sclk_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s0_r <= 1'b1;
        end else if (rise_w) begin
            s0_r <= rxd_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive control and shift register.

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_st_r <= sp_pkg::SP_RX_IDLE;
        end else begin
            unique case (rx_st_r)
                sp_pkg::SP_RX_IDLE: begin
                    if (start0_w) begin
                        rx_st_r <= sp_pkg::SP_RX_LOAD;
                    end else if (det_w) begin
                        rx_st_r <= sp_pkg::SP_RX_FRAME;
                    end
                end
                sp_pkg::SP_RX_LOAD: begin
                    rx_st_r <= sp_pkg::SP_RX_SYNC;
                end
                sp_pkg::SP_RX_SYNC: begin
                    if (final0_w) begin
                        rx_st_r <= sp_pkg::SP_RX_IDLE;
                    end
                end
                sp_pkg::SP_RX_FRAME: begin
                    if (abort_w | final1_w) begin
                        rx_st_r <= sp_pkg::SP_RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rsr_r <= sp_pkg::SP_RX1_INIT;
        end else if (rx_st_r == sp_pkg::SP_RX_LOAD) begin
            rsr_r <= sp_pkg::SP_RX0_INIT;
        end else if (det_w) begin
            rsr_r <= sp_pkg::SP_RX1_INIT;
        end else if (fall_w & recv0_w) begin
            rsr_r <= shift0_w;
        end else if (bit_stb_w) begin
            rsr_r <= shift1_w;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rxbuf_r <= sp_pkg::SP_RST_BYTE;
        end else if (final0_w) begin
            rxbuf_r <= rev8(shift0_w[7:0]);
        end else if (accept1_w) begin
            rxbuf_r <= rev8(shift1_w[8:1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit control and shift register.

    logic done_w;

    assign done_w = tsr_r[1] & (tsr_r[8:2] == 7'h00);

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_st_r <= sp_pkg::SP_TX_IDLE;
        end else if (wr_buf_w) begin
            tx_st_r <= sp_pkg::SP_TX_WAIT;
        end else begin
            unique case (tx_st_r)
                sp_pkg::SP_TX_IDLE: begin
                    tx_st_r <= sp_pkg::SP_TX_IDLE;
                end
                sp_pkg::SP_TX_WAIT: begin
                    if (is_m0_w) begin
                        tx_st_r <= sp_pkg::SP_TX_DATA;
                    end else if (roll_w) begin
                        tx_st_r <= sp_pkg::SP_TX_START;
                    end
                end
                sp_pkg::SP_TX_START: begin
                    if (roll_w) begin
                        tx_st_r <= sp_pkg::SP_TX_DATA;
                    end
                end
                sp_pkg::SP_TX_DATA: begin
                    if (done_w & (is_m0_w ? fall_w : roll_w)) begin
                        tx_st_r <= sp_pkg::SP_TX_IDLE;
                    end
                end
            endcase
        end
    end

    logic tshift_w;

    // Mode 1 data phase shifts on rollovers after the first data bit time.
    assign tshift_w = (tx_st_r == sp_pkg::SP_TX_DATA)
                    & (is_m0_w ? fall_w : roll_w);

    always_ff @(posedge clk) begin
        if (srst) begin
            tsr_r <= 9'h1ff;
        end else if (wr_buf_w) begin
            tsr_r <= {1'b1, wb_w};
        end else if (tshift_w) begin
            tsr_r <= {1'b0, tsr_r[8:1]};
        end
    end

    logic ti_set_w;
    logic ri_set_w;

    assign ti_set_w = tshift_w & done_w;
    assign ri_set_w = final0_w | accept1_w;

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered alike so data and clock stay aligned.

    logic l1_nxt;

    assign l1_nxt = is_m0_w ? (~act0_w | sclk_r)
                  : (tx_st_r == sp_pkg::SP_TX_START) ? 1'b0
                  : (tx_st_r == sp_pkg::SP_TX_DATA) ? tsr_r[0]
                  : 1'b1;

    always_ff @(posedge clk) begin
        if (srst) begin
            out0_r <= 1'b1;
            oe0_r  <= 1'b0;
            out1_r <= 1'b1;
        end else begin
            out0_r <= tsr_r[0];
            oe0_r  <= send0_w;
            out1_r <= l1_nxt;
        end
    end

    assign port_three_line_zero_out = out0_r;
    assign port_three_line_zero_oe  = oe0_r;
    assign port_three_line_one      = out1_r;

    ////////////////////////////////////////////////////////////////////////
    // Software registers; hardware sets win over a clearing write.

    always_ff @(posedge clk) begin
        if (srst) begin
            ti_r  <= 1'b0;
            ri_r  <= 1'b0;
            rb8_r <= 1'b0;
        end else begin
            ti_r <= ti_set_w
                  | (wr_ctrl_w ? wb_w[sp_pkg::SP_CTRL_TI] : ti_r);
            ri_r <= ri_set_w
                  | (wr_ctrl_w ? wb_w[sp_pkg::SP_CTRL_RI] : ri_r);
            if (accept1_w) begin
                rb8_r <= maj_w;
            end else if (wr_ctrl_w) begin
                rb8_r <= wb_w[sp_pkg::SP_CTRL_RB8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_r <= 2'h0;
            mpf_r  <= 1'b0;
            ren_r  <= 1'b0;
        end else if (wr_ctrl_w) begin
            mode_r <= wb_w[sp_pkg::SP_CTRL_MODE_LSB +: 2];
            mpf_r  <= wb_w[sp_pkg::SP_CTRL_MPF];
            ren_r  <= wb_w[sp_pkg::SP_CTRL_REN];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            smod_r <= 1'b0;
            timer_mode_reg_r <= sp_pkg::SP_RST_BYTE;
            th_r   <= sp_pkg::SP_RST_BYTE;
            rh_r   <= sp_pkg::SP_RST_BYTE;
            rl_r   <= sp_pkg::SP_RST_BYTE;
        end else if (wr_w) begin
            if (sel_pwr_w) begin
                smod_r <= wb_w[sp_pkg::SP_PWR_DOUBLE];
            end
            if (sel_timer_mode_reg_w) begin
                timer_mode_reg_r <= wb_w;
            end
            if (sel_th_w) begin
                th_r <= wb_w;
            end
            if (sel_rh_w) begin
                rh_r <= wb_w;
            end
            if (sel_rl_w) begin
                rl_r <= wb_w;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_r <= 32'h0;
        end else if (rd_setup_w) begin
            prdata_r <= rd_data_w;
        end
    end

endmodule

// ---- sim/sp_serial_port_props.sv ----
// Checker for the serial port: bus answers and mode 0 pin timing.
module sp_serial_port_props (
    input wire logic                clk,
    input wire logic                srst,
    input wire sp_pkg::sp_apb_req_t apb_req,
    input wire sp_pkg::sp_apb_rsp_t apb_rsp,
    input wire logic                port_three_line_zero_in,
    input wire logic                port_three_line_zero_out,
    input wire logic                port_three_line_zero_oe,
    input wire logic                port_three_line_one
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    // The mode field is tracked from bus writes, since it is not a pin.
    logic [1:0] mode_r;
    wire        wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    wire        oe = port_three_line_zero_oe;
    always_ff @(posedge clk) begin
        if (srst)
            mode_r <= sp_pkg::SP_MODE0;
        else if (wr && apb_req.paddr == sp_pkg::SP_OFF_CTRL)
            mode_r <= apb_req.pwdata[7:6];
    end
    ////////////////////////////////////////////////////////////////////////
    ready_high_a: assert property (apb_rsp.pready)
        else $error("pready low");
    err_access_a: assert property (apb_rsp.pslverr |->
        apb_req.psel && apb_req.penable) else $error("stray pslverr");
    unmapped_err_a: assert property (apb_req.psel && apb_req.penable &&
        apb_req.paddr > sp_pkg::SP_OFF_TCNT |-> apb_rsp.pslverr)
        else $error("no pslverr");
    reset_idle_a: assert property ($fell(srst) |->
        port_three_line_one && !oe) else $error("pins not idle after reset");
    send_start_a: assert property (
        wr && apb_req.paddr == sp_pkg::SP_OFF_BUF &&
        mode_r == sp_pkg::SP_MODE0 |-> ##[1:3] oe)
        else $error("mode 0 send did not start");
    send_mode_a: assert property (oe |-> mode_r == sp_pkg::SP_MODE0)
        else $error("line zero driven outside mode 0");
    clk_toggle_a: assert property (
        oe [*3] |-> $changed(port_three_line_one))
        else $error("shift clock not at half rate");
    data_edge_a: assert property (
        oe && $past(oe) && $changed(port_three_line_zero_out)
        |-> $fell(port_three_line_one)) else $error("data off clock fall");
    send_len_a: assert property ($rose(oe) |-> oe [*8] ##[1:12] !oe)
        else $error("mode 0 send length wrong");
    cov_send0_c: cover property ($rose(oe));
    cov_err_c: cover property (apb_rsp.pslverr);
    cov_start1_c: cover property ($fell(port_three_line_one) &&
        mode_r == 2'h1);
endmodule

// ---- sim/sp_peer.sv ----
// Serial peer: 10-bit frame sender and receiver, mode 0 shift target.
module sp_peer (
    input  wire logic line_zero,
    input  wire logic line_one,
    output logic      drv
);
    timeunit 1ns;
    timeprecision 100ps;
    // Bit time is 80 ns; the peer drives the line high when idle.
    initial drv = 1'b1;
    task automatic send(input logic [7:0] b, input int low_ns);
        // Keeps every line change off the block's clock edges.
        #1;
        drv = 1'b0;
        #(low_ns);
        if (low_ns < 80) begin
            drv = 1'b1;
            #400;
            return;
        end
        for (int i = 0; i < 8; i++) begin
            drv = b[i];
            #80;
        end
        drv = 1'b1;
        #80;
    endtask
    task automatic recv1(output logic [7:0] b);
        @(negedge line_one);
        #40;
        for (int i = 0; i < 8; i++) begin
            #80;
            b[i] = line_one;
        end
    endtask
    task automatic recv0(output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge line_one);
            b[i] = line_zero;
        end
    endtask
endmodule

// ---- sim/sp_serial_port_tb.sv ----
// Testbench for the serial port: register, mode 0 and mode 1 traffic.
module sp_serial_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                clk = 1'b0;
    logic                srst = 1'b1;
    sp_pkg::sp_apb_req_t req = '0;
    sp_pkg::sp_apb_rsp_t rsp;
    logic                z_out;
    logic                z_oe;
    logic                l_one;
    logic                p_drv;
    int                  fails = 0;
    int                  total_checks = 0;
    logic [31:0]         q;
    logic [7:0]          b;
    wire                 line0 = z_oe ? z_out : p_drv;
    initial forever #2.5 clk = ~clk;
    sp_serial_port DUT (.clk(clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
        .port_three_line_zero_in(line0), .port_three_line_zero_out(z_out),
        .port_three_line_zero_oe(z_oe), .port_three_line_one(l_one));
    sp_peer peer (.line_zero(line0), .line_one(l_one), .drv(p_drv));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1)
                break;
        end
        if (n == 50) begin
            fails++;
            give_verdict();
        end
        q = {rsp.prdata[31:1], rsp.prdata[0]};
        chk({31'h0, rsp.pslverr}, {31'h0, a > sp_pkg::SP_OFF_TCNT});
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // Polls the control register until a flag rises, bounded.
    task automatic wait_flag(input int bit_i);
        int n;
        for (n = 0; n < 400; n++) begin
            apb(1'b0, sp_pkg::SP_OFF_CTRL, '0);
            if (q[bit_i] === 1'b1)
                break;
        end
        if (n == 400) begin
            fails++;
            give_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, sp_pkg::SP_OFF_PWR, '0);
        chk(q, 32'h0);
        apb(1'b0, 8'h24, '0);
        chk(q, 32'h0);
        apb(1'b1, sp_pkg::SP_OFF_CTRL, 32'h00);
        fork
            peer.recv0(b);
            apb(1'b1, sp_pkg::SP_OFF_BUF, 32'h4b);
        join
        chk({24'h0, b}, 32'h4b);
        wait_flag(sp_pkg::SP_CTRL_TI);
        apb(1'b1, sp_pkg::SP_OFF_CTRL, 32'h10);
        wait_flag(sp_pkg::SP_CTRL_RI);
        apb(1'b0, sp_pkg::SP_OFF_BUF, '0);
        chk(q, 32'hff);
        apb(1'b0, sp_pkg::SP_OFF_CTRL, '0);
        chk(q, 32'h11);
        // Timer interrupt is never enabled while it sets the bit rate.
        apb(1'b1, sp_pkg::SP_OFF_CTRL, 32'h40);
        apb(1'b1, sp_pkg::SP_OFF_PWR, 32'h80);
        apb(1'b1, sp_pkg::SP_OFF_TIMER_MODE_REG, 32'h20);
        apb(1'b1, sp_pkg::SP_OFF_TH, 32'hff);
        fork
            peer.recv1(b);
            apb(1'b1, sp_pkg::SP_OFF_BUF, 32'hc3);
        join
        chk({24'h0, b}, 32'hc3);
        wait_flag(sp_pkg::SP_CTRL_TI);
        apb(1'b1, sp_pkg::SP_OFF_CTRL, 32'h50);
        peer.send(8'h5a, 80);
        wait_flag(sp_pkg::SP_CTRL_RI);
        chk(q, 32'h55);
        peer.send(8'h77, 80);
        apb(1'b0, sp_pkg::SP_OFF_BUF, '0);
        chk(q, 32'h5a);
        apb(1'b1, sp_pkg::SP_OFF_CTRL, 32'h50);
        peer.send(8'h00, 15);
        peer.send(8'h3c, 80);
        wait_flag(sp_pkg::SP_CTRL_RI);
        apb(1'b0, sp_pkg::SP_OFF_BUF, '0);
        chk(q, 32'h3c);
        // Mode 2 must keep its rate with the timer stopped.
        apb(1'b1, sp_pkg::SP_OFF_TIMER_MODE_REG, 32'h00);
        apb(1'b1, sp_pkg::SP_OFF_CTRL, 32'h80);
        fork
            peer.recv1(b);
            apb(1'b1, sp_pkg::SP_OFF_BUF, 32'h96);
        join
        chk({24'h0, b}, 32'h96);
        give_verdict();
    end
    // Peer waits are not bounded, so this watchdog fails and ends a stuck run at 300000 ns.
    initial begin
        #300000;
        fails++;
        give_verdict();
    end
endmodule
bind sp_serial_port sp_serial_port_props chk_i (.clk(clk), .srst(srst),
    .apb_req(apb_req), .apb_rsp(apb_rsp),
    .port_three_line_zero_in(port_three_line_zero_in),
    .port_three_line_zero_out(port_three_line_zero_out),
    .port_three_line_zero_oe(port_three_line_zero_oe),
    .port_three_line_one(port_three_line_one));
